// [src/slhm_pkg.sv]
package slhm_pkg;

  // --------------------------------------------------------------------
  // register map (byte offsets on the plain register port)
  // --------------------------------------------------------------------
  localparam logic [11:0] OFS_LINK_WATCHDOG_CFG       = 12'h124;
  localparam logic [11:0] OFS_SYNC_ERROR_PULSE_CFG    = 12'h127;
  localparam logic [11:0] OFS_CRC_ALARM_THRESHOLD_CFG = 12'h128;
  localparam logic [11:0] OFS_LINK_CTL                = 12'h129;
  localparam logic [11:0] OFS_LINK_STATUS             = 12'h12a;

  localparam logic [7:0] RST_LINK_WATCHDOG_CFG       = 8'h00;
  localparam logic [7:0] RST_SYNC_ERROR_PULSE_CFG    = 8'h00;
  localparam logic [7:0] RST_CRC_ALARM_THRESHOLD_CFG = 8'h00;
  localparam logic [7:0] RST_LINK_CTL                = 8'h00;

  // field positions
  localparam int POS_WATCHDOG_PLL_RESET_EN  = 7;
  localparam int POS_WATCHDOG_DECREMENT_SEL = 4;
  localparam int POS_WATCHDOG_THRESHOLD_SEL = 0;
  localparam int POS_SYNC_ERROR_PULSE_WIDTH = 0;
  localparam int POS_CRC_RECOVERY_COUNT_SEL = 2;
  localparam int POS_CRC_ERROR_THRESHOLD_SEL = 0;
  localparam int POS_LINK_ENABLE_CTL        = 0;

  // watchdog threshold counts, selector values 1 to 4
  localparam logic [23:0] WD_TH_SEL1 = 24'h02_0000;
  localparam logic [23:0] WD_TH_SEL2 = 24'h08_0000;
  localparam logic [23:0] WD_TH_SEL3 = 24'h20_0000;
  localparam logic [23:0] WD_TH_SEL4 = 24'h80_0000;
  localparam int          WD_MISS_CYCLES = 1024;

  // --------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       watchdogPllResetEn;
    logic       rsv6;
    logic [1:0] watchdogDecrementSel;
    logic       rsv3;
    logic [2:0] watchdogThresholdSel;
  } slhm_wdcfg_type;

  typedef struct packed {
    logic [3:0] rsv;
    logic [1:0] crcRecoveryCountSel;
    logic [1:0] crcErrorThresholdSel;
  } slhm_crccfg_type;

  typedef struct packed {
    logic        phyRxReset;
    logic        phyPllReset;
  } slhm_phyrst_type;

endpackage : slhm_pkg

// [src/slhm_serial_link_health_monitor.sv]
// Behaviour
// - watchdog reaching threshold resets receiver logic and restarts the counter
// - with pll reset enable set, expiry also resets the link pll
// - threshold select: 0 off, 1..4 give 2^17,2^19,2^21,2^23; 5-7 reserved
// - link-up spells with no crc alarm, of any length, even one cycle, step the watchdog down
// - correctable receive error drives sync low for pulse-width link clock cycles
// - pulse width is 3 bits, 0 to 7; zero suppresses error reporting
// - recovery select gives 1, 4, 16 or 64 clean multiblocks
// - error threshold select gives 1, 2, 4 or 8 errored multiblocks
// - errored multiblocks count up to the threshold; a full clean run clears the count
// - alarm sets once errored count reaches threshold without a clean run
// - alarm clears once a clean run of recovery length is seen
// - link up and no alarm: counter decrements by 1, 2, 8 or 16
// - with pll reset enable clear, expiry resets only the receiver
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

module slhm_serial_link_health_monitor #(
  parameter logic [23:0] WD_TH1 = slhm_pkg::WD_TH_SEL1, // threshold count, select 1
  parameter logic [23:0] WD_TH2 = slhm_pkg::WD_TH_SEL2, // threshold count, select 2
  parameter logic [23:0] WD_TH3 = slhm_pkg::WD_TH_SEL3, // threshold count, select 3
  parameter logic [23:0] WD_TH4 = slhm_pkg::WD_TH_SEL4  // threshold count, select 4
) (
  input  wire logic        sys_clk,      // 100 MHz device clock
  input  wire logic        rst_n,        // synchronous reset, active low
  input  wire logic [11:0] regAddr,      // register byte address
  input  wire logic [7:0]  regWdata,     // register write data
  input  wire logic        regWr,        // write strobe
  input  wire logic        regRd,        // read strobe
  output logic      [7:0]  regRdata,     // read data, cycle after strobe
  input  wire logic        linkUp,       // link healthy level
  input  wire logic        mbDone,       // one multiblock received, pulse
  input  wire logic        mbCrcErr,     // that multiblock failed crc
  input  wire logic        rxErr,        // correctable receive error, pulse
  input  wire logic        linkClkTick,  // one link clock cycle elapsed, pulse
  output logic             phyRxReset,   // receiver reset, one-cycle pulse
  output logic             phyPllReset,  // link pll reset, one-cycle pulse
  output logic             syncErrN,     // sync toward transmitter, low asserts
  output logic             crcAlarm      // crc alarm flag
);

  // --------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------
  function automatic logic [23:0] wdThreshold(input logic [2:0] sel);
    unique case (sel)
      3'h1:    wdThreshold = WD_TH1;
      3'h2:    wdThreshold = WD_TH2;
      3'h3:    wdThreshold = WD_TH3;
      3'h4:    wdThreshold = WD_TH4;
      default: wdThreshold = 24'h00_0000;
    endcase
  endfunction : wdThreshold

  function automatic logic [4:0] wdStep(input logic [1:0] sel);
    unique case (sel)
      2'h0: wdStep = 5'h01;
      2'h1: wdStep = 5'h02;
      2'h2: wdStep = 5'h08;
      2'h3: wdStep = 5'h10;
    endcase
  endfunction : wdStep

  function automatic logic [6:0] crcRecovery(input logic [1:0] sel);
    unique case (sel)
      2'h0: crcRecovery = 7'h01;
      2'h1: crcRecovery = 7'h04;
      2'h2: crcRecovery = 7'h10;
      2'h3: crcRecovery = 7'h40;
    endcase
  endfunction : crcRecovery

  function automatic logic [3:0] crcThreshold(input logic [1:0] sel);
    unique case (sel)
      2'h0: crcThreshold = 4'h1;
      2'h1: crcThreshold = 4'h2;
      2'h2: crcThreshold = 4'h4;
      2'h3: crcThreshold = 4'h8;
    endcase
  endfunction : crcThreshold

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  slhm_pkg::slhm_wdcfg_type  wdCfg;
  slhm_pkg::slhm_crccfg_type crcCfg;
  logic [7:0]                pulseCfg;
  logic                      linkEnable;

  wire hitWd    = regAddr == slhm_pkg::OFS_LINK_WATCHDOG_CFG;
  wire hitPulse = regAddr == slhm_pkg::OFS_SYNC_ERROR_PULSE_CFG;
  wire hitCrc   = regAddr == slhm_pkg::OFS_CRC_ALARM_THRESHOLD_CFG;
  wire hitCtl   = regAddr == slhm_pkg::OFS_LINK_CTL;
  wire hitStat  = regAddr == slhm_pkg::OFS_LINK_STATUS;

  // settings are expected to change only while linkEnable is low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wdCfg      <= slhm_pkg::RST_LINK_WATCHDOG_CFG;
      pulseCfg   <= slhm_pkg::RST_SYNC_ERROR_PULSE_CFG;
      crcCfg     <= slhm_pkg::RST_CRC_ALARM_THRESHOLD_CFG;
      linkEnable <= slhm_pkg::RST_LINK_CTL[slhm_pkg::POS_LINK_ENABLE_CTL];
    end else if (regWr) begin
      if (hitWd)    wdCfg      <= regWdata;
      if (hitPulse) pulseCfg   <= regWdata;
      if (hitCrc)   crcCfg     <= regWdata;
      if (hitCtl)   linkEnable <= regWdata[slhm_pkg::POS_LINK_ENABLE_CTL];
    end
  end

  // --------------------------------------------------------------------
  // watchdog
  // --------------------------------------------------------------------
  logic [23:0] wdCount;
  logic [23:0] next_wdCount;

  wire [23:0] wdLimit  = wdThreshold(wdCfg.watchdogThresholdSel);
  wire [23:0] wdDec    = {19'h0_0000, wdStep(wdCfg.watchdogDecrementSel)};
  wire        wdActive = linkEnable && (wdLimit != 24'h00_0000);
  wire        wdBad    = !linkUp || crcAlarm;
  wire        wdExpire = wdActive && wdBad && (wdCount + 24'h00_0001 >= wdLimit);

  always_comb begin
    if (!wdActive || wdExpire) begin
      next_wdCount = 24'h00_0000;
    end else if (wdBad) begin
      next_wdCount = wdCount + 24'h00_0001;
    end else if (wdCount > wdDec) begin
      // each healthy cycle steps the count down by wdDec
      next_wdCount = wdCount - wdDec;
    end else begin
      next_wdCount = 24'h00_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wdCount     <= 24'h00_0000;
      phyRxReset  <= 1'b0;
      phyPllReset <= 1'b0;
    end else begin
      wdCount     <= next_wdCount;
      phyRxReset  <= wdExpire;
      phyPllReset <= wdExpire && wdCfg.watchdogPllResetEn;
    end
  end

  // --------------------------------------------------------------------
  // sync error report pulse
  // --------------------------------------------------------------------
  logic [2:0] syncCnt;
  logic [2:0] next_syncCnt;

  wire [2:0] pulseWidth = pulseCfg[slhm_pkg::POS_SYNC_ERROR_PULSE_WIDTH +: 3];
  wire       errReport  = linkEnable && rxErr && (pulseWidth != 3'h0);

  always_comb begin
    if (!linkEnable) begin
      next_syncCnt = 3'h0;
    end else if (errReport) begin
      next_syncCnt = pulseWidth;
    end else if (linkClkTick && syncCnt != 3'h0) begin
      next_syncCnt = syncCnt - 3'h1;
    end else begin
      next_syncCnt = syncCnt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      syncCnt  <= 3'h0;
      syncErrN <= 1'b1;
    end else begin
      syncCnt  <= next_syncCnt;
      syncErrN <= next_syncCnt == 3'h0;
    end
  end

  // --------------------------------------------------------------------
  // crc alarm
  // --------------------------------------------------------------------
  logic [3:0] crcErrCnt;
  logic [6:0] cleanRun;
  logic [3:0] next_crcErrCnt;
  logic [6:0] next_cleanRun;
  logic       next_crcAlarm;

  wire [3:0] crcTh    = crcThreshold(crcCfg.crcErrorThresholdSel);
  wire [6:0] crcRec   = crcRecovery(crcCfg.crcRecoveryCountSel);
  wire       mbBad    = mbDone && mbCrcErr;
  wire       mbGood   = mbDone && !mbCrcErr;
  wire       runDone  = mbGood && (cleanRun + 7'h01 >= crcRec);
  wire       errFull  = crcErrCnt >= crcTh;
  wire       trip     = mbBad && (crcErrCnt + 4'h1 >= crcTh);

  always_comb begin
    next_crcErrCnt = crcErrCnt;
    next_cleanRun  = cleanRun;
    next_crcAlarm  = crcAlarm;
    if (!linkEnable) begin
      next_crcErrCnt = 4'h0;
      next_cleanRun  = 7'h00;
      next_crcAlarm  = 1'b0;
    end else if (mbBad) begin
      next_cleanRun = 7'h00;
      if (!errFull) begin
        next_crcErrCnt = crcErrCnt + 4'h1;
      end
      if (trip) begin
        next_crcAlarm = 1'b1;
      end
    end else if (runDone) begin
      next_crcErrCnt = 4'h0;
      next_cleanRun  = 7'h00;
      next_crcAlarm  = 1'b0;
    end else if (mbGood) begin
      next_cleanRun = cleanRun + 7'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      crcErrCnt <= 4'h0;
      cleanRun  <= 7'h00;
      crcAlarm  <= 1'b0;
    end else begin
      crcErrCnt <= next_crcErrCnt;
      cleanRun  <= next_cleanRun;
      crcAlarm  <= next_crcAlarm;
    end
  end

  // --------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------
  wire [7:0] statusWord = {3'h0, ~syncErrN, wdCount != 24'h00_0000, linkUp,
                           crcErrCnt != 4'h0, crcAlarm};
  wire [7:0] rdMux = hitWd    ? wdCfg :
                     hitPulse ? {5'h00, pulseWidth} :
                     hitCrc   ? {4'h0, crcCfg[3:0]} :
                     hitCtl   ? {7'h00, linkEnable} :
                     hitStat  ? statusWord : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= regRd ? rdMux : 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence seqCrcTrip;
    linkEnable && mbBad && (crcErrCnt + 4'h1 >= crcTh);
  endsequence

  sequence seqCleanRun;
    linkEnable && mbGood && (cleanRun + 7'h01 >= crcRec);
  endsequence

  AST_WD_EXPIRE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wdExpire |=> phyRxReset && (wdCount == 24'h00_0000))
    else $error("watchdog expiry did not reset receiver and counter");

  AST_WD_PLL: assert property (@(posedge sys_clk) disable iff (!rst_n)
    phyRxReset |-> (phyPllReset == $past(wdCfg.watchdogPllResetEn)))
    else $error("pll reset does not follow its enable");

  AST_WD_PLL_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    phyPllReset |-> phyRxReset)
    else $error("pll reset without receiver reset");

  AST_WD_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wdCfg.watchdogThresholdSel == 3'h0) [*2] |-> (wdCount == 24'h00_0000) && !phyRxReset)
    else $error("disabled watchdog is counting");

  AST_WD_UP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wdActive && wdBad && !wdExpire) |=> (wdCount == $past(wdCount) + 24'h00_0001))
    else $error("watchdog did not count up on bad link");

  AST_WD_DOWN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wdActive && !wdBad && wdCount > wdDec) |=> (wdCount == $past(wdCount) - $past(wdDec)))
    else $error("watchdog did not step down on healthy link");

  AST_SYNC_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (errReport && pulseWidth == 3'h1) ##1 (!rxErr && !linkClkTick && linkEnable)
      |-> !syncErrN)
    else $error("sync error pulse not held");

  AST_SYNC_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(syncErrN) |-> $past(linkEnable && rxErr && pulseWidth != 3'h0))
    else $error("sync asserted without a reportable error");

  AST_CRC_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seqCrcTrip |=> crcAlarm)
    else $error("crc alarm did not set at threshold");

  AST_CRC_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seqCleanRun |=> !crcAlarm && (crcErrCnt == 4'h0))
    else $error("clean run did not clear alarm and count");

  AST_CRC_CNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (linkEnable && mbBad && !errFull) |=> (crcErrCnt == $past(crcErrCnt) + 4'h1))
    else $error("errored multiblock not counted");

  sequence seqSyncStep;
    linkEnable && !errReport && linkClkTick && (syncCnt != 3'h0);
  endsequence

  AST_WD_FLOOR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wdActive && !wdBad && wdCount <= wdDec) |=> (wdCount == 24'h00_0000))
    else $error("watchdog did not floor at zero");

  AST_WD_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wdActive |=> (wdCount == 24'h00_0000) && !phyRxReset)
    else $error("inactive watchdog kept a count or reset");

  AST_SYNC_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seqSyncStep |=> (syncCnt == $past(syncCnt) - 3'h1))
    else $error("sync pulse did not count a link clock cycle");

  AST_SYNC_LINK_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !linkEnable |=> syncErrN)
    else $error("sync asserted with the link disabled");

  AST_SYNC_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((syncCnt == 3'h0) && !errReport) |=> syncErrN)
    else $error("sync asserted with no pulse running");

  AST_CRC_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !linkEnable |=> !crcAlarm && (crcErrCnt == 4'h0) && (cleanRun == 7'h00))
    else $error("disabled link kept crc state");

  AST_CRC_RUN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (linkEnable && mbGood && !runDone) |=> (cleanRun == $past(cleanRun) + 7'h01))
    else $error("clean multiblock not counted in the run");

  AST_CRC_BREAK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (linkEnable && mbBad) |=> (cleanRun == 7'h00))
    else $error("errored multiblock did not break the clean run");

  AST_CRC_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (crcAlarm && linkEnable && !runDone) |=> crcAlarm)
    else $error("crc alarm dropped without a clean run");

endmodule : slhm_serial_link_health_monitor

// [tb/slhm_tx_model.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// transmitter side: free link clock ticks, multiblocks, errors
// ------------------------------------------------------------
module slhm_tx_model (
  input  wire logic sys_clk,     // device clock
  input  wire logic rst_n,       // synchronous reset, active low
  output logic      mbDone,      // multiblock finished, pulse
  output logic      mbCrcErr,    // crc error flag beside mbDone
  output logic      rxErr,       // correctable receive error, pulse
  output logic      linkClkTick  // link clock tick, every other cycle
);
  initial begin
    mbDone   = 1'b0;
    mbCrcErr = 1'b1;
    rxErr    = 1'b0;
  end

  // link clock runs free
  always_ff @(posedge sys_clk) begin
    if (!rst_n) linkClkTick <= 1'b0;
    else linkClkTick <= ~linkClkTick;
  end

  task send_mb(input logic err);
    @(posedge sys_clk);
    mbDone   <= 1'b1;
    mbCrcErr <= err;
    @(posedge sys_clk);
    mbDone   <= 1'b0;
    // flag is stale once the strobe drops
    mbCrcErr <= ~err;
  endtask : send_mb

  task send_rx_err;
    @(posedge sys_clk);
    rxErr <= 1'b1;
    @(posedge sys_clk);
    rxErr <= 1'b0;
  endtask : send_rx_err
endmodule : slhm_tx_model

// [tb/tb_slhm_serial_link_health_monitor.sv]
`timescale 1ns/1ps

module tb_slhm_serial_link_health_monitor;
  logic        sys_clk;
  logic        rst_n;
  logic [11:0] regAddr;
  logic [7:0]  regWdata;
  logic        regWr;
  logic        regRd;
  logic        linkUp;
  logic [7:0]  regRdata;
  logic        mbDone, mbCrcErr, rxErr, linkClkTick;
  logic        phyRxReset, phyPllReset, syncErrN, crcAlarm;
  logic [7:0]  q;
  int          err_total = 0;
  int          n_checks = 0;

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  slhm_serial_link_health_monitor #(.WD_TH1(24'h4), .WD_TH2(24'h8), .WD_TH3(24'h10),
    .WD_TH4(24'h20)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .linkUp(linkUp), .mbDone(mbDone), .mbCrcErr(mbCrcErr), .rxErr(rxErr),
    .linkClkTick(linkClkTick), .phyRxReset(phyRxReset), .phyPllReset(phyPllReset),
    .syncErrN(syncErrN), .crcAlarm(crcAlarm));

  slhm_tx_model i_tx (.sys_clk(sys_clk), .rst_n(rst_n), .mbDone(mbDone),
    .mbCrcErr(mbCrcErr), .rxErr(rxErr), .linkClkTick(linkClkTick));

  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1 q = regRdata;
  endtask : rd

  // settings change only with the link disabled
  task setcfg(input logic [11:0] a, input logic [7:0] d);
    wr(slhm_pkg::OFS_LINK_CTL, 8'h00);
    wr(a, d);
    wr(slhm_pkg::OFS_LINK_CTL, 8'h01);
  endtask : setcfg

  // bad spell d, good spell u, then bad until expiry, twice
  task wd_run(input logic [7:0] cfg, input int d, input int u, input int e1, input int th);
    int n;
    setcfg(slhm_pkg::OFS_LINK_WATCHDOG_CFG, cfg);
    @(posedge sys_clk);
    if (d > 0) begin
      linkUp <= 1'b0;
      repeat (d) @(posedge sys_clk);
      linkUp <= 1'b1;
      repeat (u) @(posedge sys_clk);
    end
    linkUp <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      // at least one edge, so a pulse just seen is not counted again
      do begin
        @(posedge sys_clk);
        #1 n++;
      end while (n < 100 && phyRxReset !== 1'b1);
      chk("reset cycles", 8'(n), 8'(k == 0 ? e1 : th));
      chk("pll reset", {7'h0, phyPllReset}, {7'h0, cfg[7] && n < 100});
    end
    linkUp <= 1'b1;
  endtask : wd_run

  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  initial begin
    #300000;
    err_total++;
    stop_test;
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    int t;
    int r;
    int ticks;
    rst_n    <= 1'b0;
    regAddr  <= 12'h000;
    regWdata <= 8'h00;
    regWr    <= 1'b0;
    regRd    <= 1'b0;
    linkUp   <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(slhm_pkg::OFS_LINK_WATCHDOG_CFG);
    chk("wd cfg reset", q, slhm_pkg::RST_LINK_WATCHDOG_CFG);
    rd(slhm_pkg::OFS_SYNC_ERROR_PULSE_CFG);
    chk("pulse cfg reset", q, 8'h00);
    rd(slhm_pkg::OFS_CRC_ALARM_THRESHOLD_CFG);
    chk("crc cfg reset", q, 8'h00);
    wr(slhm_pkg::OFS_SYNC_ERROR_PULSE_CFG, 8'hff);
    rd(slhm_pkg::OFS_SYNC_ERROR_PULSE_CFG);
    chk("pulse cfg bits", q, 8'h07);
    wr(slhm_pkg::OFS_CRC_ALARM_THRESHOLD_CFG, 8'hff);
    rd(slhm_pkg::OFS_CRC_ALARM_THRESHOLD_CFG);
    chk("crc cfg bits", q, 8'h0f);
    rd(12'h130);
    chk("unmapped read", q, 8'h00);
    $display("test registers done");

    wd_run(8'h01, 0, 0, 4, 4);
    wd_run(8'h82, 0, 0, 8, 8);
    wd_run(8'h03, 0, 0, 16, 16);
    wd_run(8'ha4, 0, 0, 32, 32);
    wd_run(8'h01, 3, 1, 2, 4);
    wd_run(8'h12, 5, 2, 7, 8);
    wd_run(8'h31, 3, 1, 4, 4);
    wd_run(8'h80, 0, 0, 100, 100);
    wd_run(8'h85, 0, 0, 100, 100);
    setcfg(slhm_pkg::OFS_LINK_WATCHDOG_CFG, 8'h00);
    $display("test watchdog done");

    for (int w = 0; w < 8; w++) begin
      setcfg(slhm_pkg::OFS_SYNC_ERROR_PULSE_CFG, 8'(w));
      i_tx.send_rx_err();
      ticks = 0;
      // first look is right after the edge that took the error
      repeat (40) begin
        #1 if (syncErrN === 1'b0 && linkClkTick === 1'b1) ticks++;
        @(posedge sys_clk);
      end
      #1 chk("sync ticks", 8'(ticks), 8'(w));
      chk("sync idle", {7'h0, syncErrN}, 8'h01);
    end
    $display("test sync done");

    for (int i = 0; i < 4; i++) begin
      t = 1 << i;
      r = 1 << (2 * i);
      setcfg(slhm_pkg::OFS_CRC_ALARM_THRESHOLD_CFG, 8'(5 * i));
      repeat (t - 1) i_tx.send_mb(1'b1);
      @(posedge sys_clk);
      #1 chk("alarm early", {7'h0, crcAlarm}, 8'h00);
      i_tx.send_mb(1'b1);
      @(posedge sys_clk);
      #1 chk("alarm set", {7'h0, crcAlarm}, 8'h01);
      rd(slhm_pkg::OFS_LINK_STATUS);
      chk("status", q, 8'h07);
      repeat (r - 1) i_tx.send_mb(1'b0);
      @(posedge sys_clk);
      #1 chk("alarm held", {7'h0, crcAlarm}, 8'h01);
      i_tx.send_mb(1'b0);
      @(posedge sys_clk);
      #1 chk("alarm clear", {7'h0, crcAlarm}, 8'h00);
      if (i > 0) begin
        repeat (t - 1) i_tx.send_mb(1'b1);
        repeat (r - 1) i_tx.send_mb(1'b0);
        i_tx.send_mb(1'b1);
        @(posedge sys_clk);
        #1 chk("count kept", {7'h0, crcAlarm}, 8'h01);
      end
    end
    $display("test crc done");
    stop_test;
  end
endmodule : tb_slhm_serial_link_health_monitor
